// *** flash_if_map.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit AXI4-Lite slave with word-aligned registers
`ifndef FLASH_IF_MAP_SVH
`define FLASH_IF_MAP_SVH
`define OFS_FOURTH_CONFIG   8'h00
`define OFS_CFG_NONVOLATILE 8'h04
`define OFS_CFG_VOLATILE    8'h08
`define OFS_STATUS          8'h0c
`define OFS_START_ADDR      8'h10
`define FOURTH_CONFIG_RESET 8'h00
`define CFG5_RESET          8'h40
`define WRAP_ENABLE_BIT     4
`define WRAP_LENGTH_LSB     0
`define RATE_SELECT_BIT     1
`define WIDTH_SELECT_BIT    0
`define WRAP_MIN_BYTES      32'h0000_0008
`define LEGACY_BITS_PER_BYTE 3'h7
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// *** flash_if_pkg.sv ***
// types shared by the interface configuration and wrap sequencer
// offsets and reset values live in flash_if_map.svh
package flash_if_pkg;
  typedef struct packed {
    logic       reserved7;
    logic       reserved6;
    logic [3:0] reserved;
    logic       rate_select;
    logic       width_select;
  } cfg5_s;
  typedef struct packed {
    logic       wrap_enable;
    logic [1:0] wrap_length;
  } wrap_cfg_s;
  typedef struct packed {
    logic octal;
    logic ddr;
  } mode_s;
  typedef logic [31:0] addr_t;
endpackage

// *** flash_if_core.sv ***
// interface configuration registers and burst-wrap read address sequencer
// assumes the host drives sck and cs_n asynchronously to clk; bus is AXI4-Lite
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "flash_if_map.svh"

// Notes on behaviour
// - wrap off: addresses increment linearly
// - 8-byte wrap: low three bits cycle
// - 16-byte wrap: 0f returns to 00
// - 32-byte wrap: 1f returns to 00
// - 64-byte wrap: 3f returns to 00
// - first byte is addressed byte, loops
// - rate bit only matters in octal
// - width bit: 0 single line, 1 octal
// - octal carries everything on eight lines
// - wrap enable: 0 linear, 1 wrapped
// - wrap length 00/01/10/11 = 8/16/32/64
module flash_if_core (
  // system
  input  wire logic                clk,
  input  wire logic                nrst,
  // link pins from host
  input  wire logic                sck,
  input  wire logic                cs_n,
  // array side
  output flash_if_pkg::addr_t      byte_addr,
  output logic                     byte_strobe,
  output flash_if_pkg::mode_s      active_mode,
  output logic [3:0]               io_lanes,
  // axi4-lite write
  input  wire logic [7:0]          s_awaddr,
  input  wire logic                s_awvalid,
  output logic                     s_awready,
  input  wire logic [31:0]         s_wdata,
  input  wire logic [3:0]          s_wstrb,
  input  wire logic                s_wvalid,
  output logic                     s_wready,
  output logic [1:0]               s_bresp,
  output logic                     s_bvalid,
  input  wire logic                s_bready,
  // axi4-lite read
  input  wire logic [7:0]          s_araddr,
  input  wire logic                s_arvalid,
  output logic                     s_arready,
  output logic [31:0]              s_rdata,
  output logic [1:0]               s_rresp,
  output logic                     s_rvalid,
  input  wire logic                s_rready
);
  import flash_if_pkg::*;

  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // pin synchronisers; a change counts once stages two and three agree
  logic [2:0] sck_s;
  logic [2:0] cs_s;
  logic       sck_f;
  logic       cs_f;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s <= 3'h0;
      cs_s  <= 3'h7;
      sck_f <= 1'b0;
      cs_f  <= 1'b1;
    end else begin
      sck_s <= {sck_s[1:0], sck};
      cs_s  <= {cs_s[1:0], cs_n};
      if (sck_s[1] == sck_s[2]) sck_f <= sck_s[2];
      if (cs_s[1] == cs_s[2]) cs_f <= cs_s[2];
    end
  end

  logic sck_next;
  logic cs_next;
  logic sck_rise;
  logic sck_fall;
  logic frame_start;
  logic in_frame;
  assign sck_next    = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_f;
  assign cs_next     = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_f;
  assign sck_rise    = !sck_f && sck_next && !cs_f;
  assign sck_fall    = sck_f && !sck_next && !cs_f;
  assign frame_start = cs_f && !cs_next;
  assign in_frame    = !cs_f;

  // registers
  logic [7:0] fourth_config_register;
  cfg5_s      interface_config_nonvolatile;
  cfg5_s      interface_config_volatile;
  addr_t      start_addr;
  logic       load_pending;
  wrap_cfg_s  wrap_cfg;
  assign wrap_cfg.wrap_enable = fourth_config_register[`WRAP_ENABLE_BIT];
  assign wrap_cfg.wrap_length = fourth_config_register[`WRAP_LENGTH_LSB +: 2];

  // axi write channel
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  assign do_write = aw_held && w_held && !s_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h0;
      w_strb    <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `RESP_OKAY;
    end else begin
      s_awready <= !aw_held && !(s_awvalid && s_awready) && !s_bvalid;
      s_wready  <= !w_held && !(s_wvalid && s_wready) && !s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (do_write) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        unique case (aw_addr)
          `OFS_FOURTH_CONFIG, `OFS_CFG_NONVOLATILE, `OFS_CFG_VOLATILE,
          `OFS_START_ADDR: s_bresp <= `RESP_OKAY;
          default:         s_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // register storage; reserved bits are stored as the host writes them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fourth_config_register       <= `FOURTH_CONFIG_RESET;
      interface_config_nonvolatile <= `CFG5_RESET;
      interface_config_volatile    <= `CFG5_RESET;
      start_addr                   <= 32'h0;
      load_pending                 <= 1'b1;
    end else begin
      load_pending <= 1'b0;
      if (load_pending) interface_config_volatile <= interface_config_nonvolatile;
      if (do_write) begin
        if (aw_addr == `OFS_FOURTH_CONFIG && w_strb[0]) fourth_config_register <= w_data[7:0];
        if (aw_addr == `OFS_CFG_NONVOLATILE && w_strb[0])
          interface_config_nonvolatile <= w_data[7:0];
        if (aw_addr == `OFS_CFG_VOLATILE && w_strb[0] && !load_pending)
          interface_config_volatile <= w_data[7:0];
        if (aw_addr == `OFS_START_ADDR) begin
          for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) start_addr[i*8 +: 8] <= w_data[i*8 +: 8];
          end
        end
      end
    end
  end

  // axi read channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= `RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !(s_arvalid && s_arready);
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= `RESP_OKAY;
        unique case (s_araddr)
          `OFS_FOURTH_CONFIG:   s_rdata <= {24'h0, fourth_config_register};
          `OFS_CFG_NONVOLATILE: s_rdata <= {24'h0, interface_config_nonvolatile};
          `OFS_CFG_VOLATILE:    s_rdata <= {24'h0, interface_config_volatile};
          `OFS_STATUS:          s_rdata <= {29'h0, in_frame, active_mode};
          `OFS_START_ADDR:      s_rdata <= start_addr;
          default: begin
            s_rdata <= 32'h0;
            s_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // active mode follows the volatile copy only outside a frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_mode <= 2'h0;
      io_lanes    <= 4'h1;
    end else if (cs_f && cs_next) begin
      active_mode.octal <= interface_config_volatile.width_select;
      active_mode.ddr   <= interface_config_volatile.width_select
                           && interface_config_volatile.rate_select;
      io_lanes <= interface_config_volatile.width_select ? 4'h8 : 4'h1;
    end
  end

  // byte pacing: legacy 8 rises, octal sdr 1 rise, octal ddr each edge
  logic [2:0] bit_cnt;
  logic       byte_evt;
  always_comb begin
    if (active_mode.ddr) byte_evt = sck_rise || sck_fall;
    else if (active_mode.octal) byte_evt = sck_rise;
    else byte_evt = sck_rise && (bit_cnt == `LEGACY_BITS_PER_BYTE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bit_cnt <= 3'h0;
    else if (frame_start) bit_cnt <= 3'h0;
    else if (sck_rise && !active_mode.octal) bit_cnt <= bit_cnt + 3'h1;
  end

  // address sequencer
  addr_t cur_addr;
  addr_t wrap_mask;
  addr_t next_addr;
  addr_t step_addr;
  assign wrap_mask = (`WRAP_MIN_BYTES << wrap_cfg.wrap_length) - 32'h1;
  assign step_addr = cur_addr + 32'h1;
  assign next_addr = wrap_cfg.wrap_enable
                   ? ((cur_addr & ~wrap_mask) | (step_addr & wrap_mask))
                   : step_addr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_addr    <= 32'h0;
      byte_addr   <= 32'h0;
      byte_strobe <= 1'b0;
    end else begin
      byte_strobe <= byte_evt;
      if (frame_start) cur_addr <= start_addr;
      else if (byte_evt) begin
        byte_addr <= cur_addr;
        cur_addr  <= next_addr;
      end
    end
  end

  // marks that the next byte is the first of the frame
  logic first_due;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) first_due <= 1'b0;
    else if (frame_start) first_due <= 1'b1;
    else if (byte_evt) first_due <= 1'b0;
  end

  // checks
  a_linear_step: assert property (@(posedge clk) disable iff (!rst_n)
    byte_evt && !wrap_cfg.wrap_enable && !frame_start |=> cur_addr == $past(cur_addr) + 32'h1)
    else $error("linear address did not step by one");

  a_wrap_eight: assert property (@(posedge clk) disable iff (!rst_n)
    byte_evt && wrap_cfg == 3'b100 |=> cur_addr[31:3] == $past(cur_addr[31:3])
      && cur_addr[2:0] == 3'($past(cur_addr[2:0]) + 3'h1))
    else $error("8-byte wrap step wrong");

  a_wrap_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
    byte_evt && wrap_cfg == 3'b101 |=> cur_addr[31:4] == $past(cur_addr[31:4])
      && cur_addr[3:0] == 4'($past(cur_addr[3:0]) + 4'h1))
    else $error("16-byte wrap step wrong");

  a_wrap_thirtytwo: assert property (@(posedge clk) disable iff (!rst_n)
    byte_evt && wrap_cfg == 3'b110 |=> cur_addr[31:5] == $past(cur_addr[31:5])
      && cur_addr[4:0] == 5'($past(cur_addr[4:0]) + 5'h01))
    else $error("32-byte wrap step wrong");

  a_wrap_sixtyfour: assert property (@(posedge clk) disable iff (!rst_n)
    byte_evt && wrap_cfg == 3'b111 |=> cur_addr[31:6] == $past(cur_addr[31:6])
      && cur_addr[5:0] == 6'($past(cur_addr[5:0]) + 6'h01))
    else $error("64-byte wrap step wrong");

  sequence first_byte_out;
    byte_evt && first_due ##1 byte_strobe;
  endsequence
  a_first_byte: assert property (@(posedge clk) disable iff (!rst_n)
    first_byte_out |-> byte_addr == $past(start_addr))
    else $error("first byte not the addressed byte");

  a_ddr_octal_only: assert property (@(posedge clk) disable iff (!rst_n)
    active_mode.ddr |-> active_mode.octal && io_lanes == 4'h8)
    else $error("ddr active outside octal protocol");

  a_mode_idle_load: assert property (@(posedge clk) disable iff (!rst_n)
    cs_f && cs_next |=> active_mode.octal == $past(interface_config_volatile.width_select))
    else $error("idle mode not taken from volatile copy");

  a_volatile_load: assert property (@(posedge clk) disable iff (!rst_n)
    load_pending |=> interface_config_volatile == $past(interface_config_nonvolatile))
    else $error("volatile copy not loaded from nonvolatile");

  a_mode_hold: assert property (@(posedge clk) disable iff (!rst_n)
    in_frame && !cs_next |=> $stable(active_mode) && $stable(io_lanes))
    else $error("mode changed inside a transaction");

endmodule // flash_if_core

// *** host_link_model.sv ***
// host side of the link: drives the serial clock and the select pin
// sck toggles only inside a frame at an 80 ns period, idles low
`timescale 1ns/100ps
module host_link_model (
  // link pins
  output logic sck,
  output logic cs_n
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
  end
  task automatic sel(input logic on);
    #37 cs_n = ~on;
    #37;
  endtask
  // n half periods of 40 ns; sck toggles at the end of each one
  task automatic run(input int n);
    repeat (n) #40 sck = ~sck;
  endtask
endmodule // host_link_model

// *** tb_octal_read_wrap_and_mode_select.sv ***
// self-checking bench for the wrap sequencer and interface config
// drives the axi4-lite slave; host_link_model drives the link pins
`timescale 1ns/100ps
`include "flash_if_map.svh"
module tb_octal_read_wrap_and_mode_select;
  import flash_if_pkg::*;
  logic        clk, nrst, sck, cs_n, byte_strobe;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  io_lanes;
  logic [1:0]  bresp, rresp, r;
  addr_t       byte_addr;
  mode_s       active_mode;
  addr_t       got[$];
  int          miscompares, n_compared;
  host_link_model m (.sck(sck), .cs_n(cs_n));
  flash_if_core dut (.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n),
    .byte_addr(byte_addr), .byte_strobe(byte_strobe), .active_mode(active_mode),
    .io_lanes(io_lanes), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (byte_strobe === 1'b1) got.push_back(byte_addr);
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    n_compared++;
    if (a !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rst();
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  // waits for the mode to settle, then judges lanes and mode
  task automatic mode_is(input logic [3:0] l, input logic [1:0] md);
    int k;
    k = 0;
    while (io_lanes !== l && k < 50) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
    cmp(32'(io_lanes), 32'(l));
    cmp(32'(active_mode), 32'(md));
  endtask
  // g group size (0 linear), n bytes, h half periods per byte
  task automatic frame(input addr_t s, input int g, input int n, input int h);
    addr_t e;
    int    k;
    got.delete();
    wr(`OFS_START_ADDR, s, r);
    m.sel(1'b1);
    m.run(n * h);
    k = 0;
    while (got.size() < n && k < 200) begin
      @(posedge clk);
      k++;
    end
    m.sel(1'b0);
    cmp(32'(got.size()), 32'(n));
    e = s;
    for (int i = 0; i < n && i < got.size(); i++) begin
      cmp(got[i], e);
      e = (g == 0) ? e + 1 : (e & ~addr_t'(g - 1)) | ((e + 1) & addr_t'(g - 1));
    end
  endtask
  task automatic t_reset();
    rd(`OFS_FOURTH_CONFIG, d, r);
    cmp(d, 32'h00);
    rd(`OFS_CFG_VOLATILE, d, r);
    cmp(d, 32'h40);
    mode_is(4'h1, 2'h0);
    rd(8'h20, d, r);
    cmp(32'(r), 32'(`RESP_SLVERR));
    wr(8'h20, 32'h1, r);
    cmp(32'(r), 32'(`RESP_SLVERR));
  endtask
  task automatic t_wrap();
    addr_t st[4];
    st = '{32'h107, 32'h10c, 32'h11e, 32'h12e};
    wr(`OFS_CFG_VOLATILE, 32'h41, r);
    mode_is(4'h8, 2'h2);
    for (int l = 0; l < 4; l++) begin
      wr(`OFS_FOURTH_CONFIG, 32'h10 | l, r);
      frame(st[l], 8 << l, (8 << l) + 3, 2);
    end
  endtask
  task automatic t_ddr();
    wr(`OFS_CFG_VOLATILE, 32'h43, r);
    mode_is(4'h8, 2'h3);
    frame(32'h13c, 64, 8, 1);
  endtask
  task automatic t_legacy_rate();
    wr(`OFS_FOURTH_CONFIG, 32'h0, r);
    wr(`OFS_CFG_VOLATILE, 32'h42, r);
    mode_is(4'h1, 2'h0);
    frame(32'h1fe, 0, 3, 16);
  endtask
  task automatic t_midframe();
    m.sel(1'b1);
    wr(`OFS_CFG_VOLATILE, 32'h41, r);
    repeat (20) @(posedge clk);
    cmp(32'(io_lanes), 32'h1);
    rd(`OFS_STATUS, d, r);
    cmp(d, 32'h4);
    m.sel(1'b0);
    mode_is(4'h8, 2'h2);
  endtask
  task automatic t_nonvolatile();
    wr(`OFS_CFG_NONVOLATILE, 32'h43, r);
    rd(`OFS_CFG_NONVOLATILE, d, r);
    cmp(d, 32'h43);
    // nrst also returns the nonvolatile copy to its reset value
    rst();
    rd(`OFS_CFG_NONVOLATILE, d, r);
    cmp(d, 32'(`CFG5_RESET));
    rd(`OFS_CFG_VOLATILE, d, r);
    cmp(d, 32'(`CFG5_RESET));
    mode_is(4'h1, 2'h0);
  endtask
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    rst();
    t_reset();
    t_wrap();
    t_ddr();
    t_legacy_rate();
    t_midframe();
    t_nonvolatile();
    complete_run();
  end
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
endmodule // tb_octal_read_wrap_and_mode_select
